// File: logic/ldc_addr_pointer.sv
// register address pointer of the control port
// assumes access and load strobes are one-cycle pulses on i_sys_clk
module ldc_addr_pointer (
	input  wire logic       i_sys_clk,    // system clock
	input  wire logic       i_resetn,     // async reset, active low
	input  wire logic       i_load,       // load a new pointer value
	input  wire logic [7:0] i_load_value, // value to load
	input  wire logic       i_access,     // one access done this cycle
	input  wire logic       i_auto_incr,  // step after each access
	output logic      [7:0] o_addr,       // address used this cycle
	output logic      [7:0] o_ptr         // registered pointer
);
	typedef struct packed {
		logic [7:0] ptr;
	} ldc_ptr_state_t;

	ldc_ptr_state_t state_r;
	ldc_ptr_state_t state_nxt;

	// a load in the same cycle as an access targets the loaded address
	always_comb begin
		o_addr    = i_load ? i_load_value : state_r.ptr;
		state_nxt = state_r;
		state_nxt.ptr = o_addr;
		if (i_access && i_auto_incr) begin
			state_nxt.ptr = o_addr + ldc_pkg::PTR_STEP;
		end
	end

	// pointer register
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r.ptr <= ldc_pkg::RST_POINTER;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_ptr = state_r.ptr;
endmodule

// File: logic/ldc_cfg_if.sv
// group settings passed from the register bank to the per-module selector
// assumes both ends share one clock
interface ldc_cfg_if;
	logic [ldc_pkg::NUM_MODULES-1:0] group_mode;     // per-module group select
	logic [ldc_pkg::DATA_W-1:0]      group_intens;   // group intensity code
	logic [ldc_pkg::DATA_W-1:0]      group_mix_a;    // group first colour share
	logic [ldc_pkg::DATA_W-1:0]      group_mix_b;    // group second colour share
	logic                            outputs_active; // chip on and not forced off
	modport src  (output group_mode, group_intens, group_mix_a, group_mix_b, outputs_active);
	modport sink (input group_mode, group_intens, group_mix_a, group_mix_b, outputs_active);
endinterface

// File: logic/ldc_config_bank.sv
// configuration bank of the rgb led driver: six 8-bit control registers
// assumes a serial control front end on i_sys_clk that presents
// address loads and byte reads and writes as one-cycle pulses
module ldc_config_bank (
	input  wire logic           i_sys_clk,         // system clock, 100 MHz
	input  wire logic           i_resetn,          // async reset, active low
	input  wire logic           i_addr_load,       // load register pointer
	input  wire logic [7:0]     i_addr_value,      // pointer value to load
	input  wire logic           i_reg_wr,          // write one byte
	input  wire logic [7:0]     i_reg_wdata,       // byte to write
	input  wire logic           i_reg_rd,          // read one byte
	input  ldc_pkg::ldc_bytes_t i_own_intens,      // per-module intensity
	input  ldc_pkg::ldc_bytes_t i_own_mix_a,       // per-module first share
	input  ldc_pkg::ldc_bytes_t i_own_mix_b,       // per-module second share
	output logic [7:0]          o_reg_rdata,       // read byte
	output logic                o_rd_valid,        // read byte valid, pulse
	output logic                o_addr_miss,       // access outside bank, pulse
	output logic [7:0]          o_reg_ptr,         // current pointer
	output logic                o_chip_enable,     // device enabled
	output logic                o_log_dimming,     // logarithmic curve
	output logic                o_power_save_en,   // auto power saving
	output logic                o_auto_increment,  // pointer stepping on
	output logic                o_pwm_dither_en,   // pwm dithering on
	output logic                o_max_current_35ma,// 35 mA ceiling
	output logic                o_all_outputs_off, // all leds forced off
	output logic                o_outputs_active,  // sinks may conduct
	output logic [7:0]          o_module_group_mode, // per-module group select
	output ldc_pkg::ldc_bytes_t o_eff_intens,      // effective intensity
	output ldc_pkg::ldc_bytes_t o_eff_mix_a,       // effective first share
	output ldc_pkg::ldc_bytes_t o_eff_mix_b        // effective second share
);
	typedef struct packed {
		logic [7:0] chip_control;
		logic [7:0] feature_options;
		logic [7:0] module_group_select;
		logic [7:0] group_intensity;
		logic [7:0] group_mix_first;
		logic [7:0] group_mix_second;
		logic [7:0] rdata;
		logic       rd_valid;
		logic       addr_miss;
		logic       outputs_active;
	} ldc_bank_state_t;

	ldc_bank_state_t state_r;
	ldc_bank_state_t state_nxt;

	logic       access;
	logic [7:0] acc_addr;
	logic [7:0] rd_mux;
	logic       hit;

	ldc_cfg_if cfg_bus ();

	// a write and a read in one cycle count as one access
	assign access = i_reg_wr | i_reg_rd;

	// pointer lives apart so the front end can reuse it for bursts
	ldc_addr_pointer u_ptr (
		.i_sys_clk    (i_sys_clk),
		.i_resetn     (i_resetn),
		.i_load       (i_addr_load),
		.i_load_value (i_addr_value),
		.i_access     (access),
		.i_auto_incr  (state_r.feature_options[ldc_pkg::BIT_AUTO_INCR]),
		.o_addr       (acc_addr),
		.o_ptr        (o_reg_ptr)
	);

	// read selection; a read sees the value before a same-cycle write
	always_comb begin
		hit    = 1'b1;
		rd_mux = ldc_pkg::READ_MISS_VALUE;
		case (acc_addr)
			ldc_pkg::OFS_CHIP_CONTROL: rd_mux = state_r.chip_control;
			ldc_pkg::OFS_FEATURES:     rd_mux = state_r.feature_options;
			ldc_pkg::OFS_GROUP_SELECT: rd_mux = state_r.module_group_select;
			ldc_pkg::OFS_GROUP_INTENS: rd_mux = state_r.group_intensity;
			ldc_pkg::OFS_GROUP_MIX_A:  rd_mux = state_r.group_mix_first;
			ldc_pkg::OFS_GROUP_MIX_B:  rd_mux = state_r.group_mix_second;
			default: begin
				hit    = 1'b0;
				rd_mux = ldc_pkg::READ_MISS_VALUE;
			end
		endcase
	end

	// register writes and access status
	always_comb begin
		state_nxt           = state_r;
		state_nxt.rd_valid  = i_reg_rd;
		state_nxt.addr_miss = access & ~hit;
		if (i_reg_rd) begin
			state_nxt.rdata = rd_mux;
		end
		if (i_reg_wr) begin
			// whole bytes are stored, reserved bits included, so they read back
			case (acc_addr)
				ldc_pkg::OFS_CHIP_CONTROL: state_nxt.chip_control = i_reg_wdata;
				ldc_pkg::OFS_FEATURES: state_nxt.feature_options = i_reg_wdata;
				ldc_pkg::OFS_GROUP_SELECT: state_nxt.module_group_select = i_reg_wdata;
				ldc_pkg::OFS_GROUP_INTENS: state_nxt.group_intensity = i_reg_wdata;
				ldc_pkg::OFS_GROUP_MIX_A: state_nxt.group_mix_first = i_reg_wdata;
				ldc_pkg::OFS_GROUP_MIX_B: state_nxt.group_mix_second = i_reg_wdata;
				default: begin
					state_nxt.chip_control = state_r.chip_control;
				end
			endcase
		end
		state_nxt.outputs_active = state_nxt.chip_control[ldc_pkg::BIT_CHIP_ENABLE]
			& ~state_nxt.feature_options[ldc_pkg::BIT_ALL_OFF];
	end

	// state register
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r.chip_control        <= ldc_pkg::RST_CHIP_CONTROL;
			state_r.feature_options     <= ldc_pkg::RST_FEATURES;
			state_r.module_group_select <= ldc_pkg::RST_GROUP_SELECT;
			state_r.group_intensity     <= ldc_pkg::RST_GROUP_INTENS;
			state_r.group_mix_first     <= ldc_pkg::RST_GROUP_MIX_A;
			state_r.group_mix_second    <= ldc_pkg::RST_GROUP_MIX_B;
			state_r.rdata               <= ldc_pkg::READ_MISS_VALUE;
			state_r.rd_valid            <= 1'b0;
			state_r.addr_miss           <= 1'b0;
			state_r.outputs_active      <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// group settings to the selector, all straight from registers
	assign cfg_bus.group_mode     = state_r.module_group_select;
	assign cfg_bus.group_intens   = state_r.group_intensity;
	assign cfg_bus.group_mix_a    = state_r.group_mix_first;
	assign cfg_bus.group_mix_b    = state_r.group_mix_second;
	assign cfg_bus.outputs_active = state_r.outputs_active;

	// selector adds one cycle after a register write
	ldc_group_mux u_mux (
		.i_sys_clk    (i_sys_clk),
		.i_resetn     (i_resetn),
		.cfg          (cfg_bus),
		.i_own_intens (i_own_intens),
		.i_own_mix_a  (i_own_mix_a),
		.i_own_mix_b  (i_own_mix_b),
		.o_intens     (o_eff_intens),
		.o_mix_a      (o_eff_mix_a),
		.o_mix_b      (o_eff_mix_b)
	);

	// status and option outputs, each a register bit or byte
	assign o_reg_rdata         = state_r.rdata;
	assign o_rd_valid          = state_r.rd_valid;
	assign o_addr_miss         = state_r.addr_miss;
	assign o_chip_enable       = state_r.chip_control[ldc_pkg::BIT_CHIP_ENABLE];
	assign o_log_dimming       = state_r.feature_options[ldc_pkg::BIT_LOG_DIMMING];
	assign o_power_save_en     = state_r.feature_options[ldc_pkg::BIT_POWER_SAVE];
	assign o_auto_increment    = state_r.feature_options[ldc_pkg::BIT_AUTO_INCR];
	assign o_pwm_dither_en     = state_r.feature_options[ldc_pkg::BIT_PWM_DITHER];
	assign o_max_current_35ma  = state_r.feature_options[ldc_pkg::BIT_MAX_CURRENT];
	assign o_all_outputs_off   = state_r.feature_options[ldc_pkg::BIT_ALL_OFF];
	assign o_outputs_active    = state_r.outputs_active;
	assign o_module_group_mode = state_r.module_group_select;
endmodule

// File: logic/ldc_group_mux.sv
// per-module choice between own settings and group settings
// assumes own settings come from logic on the same clock
module ldc_group_mux (
	input  wire logic         i_sys_clk,    // system clock
	input  wire logic         i_resetn,     // async reset, active low
	ldc_cfg_if.sink           cfg,          // group settings
	input  ldc_pkg::ldc_bytes_t i_own_intens, // per-module intensity
	input  ldc_pkg::ldc_bytes_t i_own_mix_a,  // per-module first share
	input  ldc_pkg::ldc_bytes_t i_own_mix_b,  // per-module second share
	output ldc_pkg::ldc_bytes_t o_intens,     // effective intensity
	output ldc_pkg::ldc_bytes_t o_mix_a,      // effective first share
	output ldc_pkg::ldc_bytes_t o_mix_b       // effective second share
);
	typedef struct packed {
		ldc_pkg::ldc_bytes_t intens;
		ldc_pkg::ldc_bytes_t mix_a;
		ldc_pkg::ldc_bytes_t mix_b;
	} ldc_mux_state_t;

	ldc_mux_state_t state_r;
	ldc_mux_state_t state_nxt;

	// one selector per module; a disabled or forced-off chip shows zero
	always_comb begin
		state_nxt = '0;
		for (int m = 0; m < ldc_pkg::NUM_MODULES; m++) begin
			if (cfg.outputs_active) begin
				if (cfg.group_mode[m]) begin
					state_nxt.intens[m] = cfg.group_intens;
					state_nxt.mix_a[m]  = cfg.group_mix_a;
					state_nxt.mix_b[m]  = cfg.group_mix_b;
				end else begin
					state_nxt.intens[m] = i_own_intens[m];
					state_nxt.mix_a[m]  = i_own_mix_a[m];
					state_nxt.mix_b[m]  = i_own_mix_b[m];
				end
			end
		end
	end

	// output registers
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_intens = state_r.intens;
	assign o_mix_a  = state_r.mix_a;
	assign o_mix_b  = state_r.mix_b;
endmodule

// File: logic/ldc_pkg.sv
// constants for the led driver configuration bank
// assumes one 8-bit register port fed by the serial control front end
package ldc_pkg;
	localparam int          NUM_MODULES      = 8;
	localparam int          DATA_W           = 8;
	// register offsets
	localparam logic [7:0]  OFS_CHIP_CONTROL = 8'h00;
	localparam logic [7:0]  OFS_FEATURES     = 8'h01;
	localparam logic [7:0]  OFS_GROUP_SELECT = 8'h02;
	localparam logic [7:0]  OFS_GROUP_INTENS = 8'h03;
	localparam logic [7:0]  OFS_GROUP_MIX_A  = 8'h04;
	localparam logic [7:0]  OFS_GROUP_MIX_B  = 8'h05;
	// reset values
	localparam logic [7:0]  RST_CHIP_CONTROL = 8'h00;
	localparam logic [7:0]  RST_FEATURES     = 8'h3C;
	localparam logic [7:0]  RST_GROUP_SELECT = 8'h00;
	localparam logic [7:0]  RST_GROUP_INTENS = 8'hFF;
	localparam logic [7:0]  RST_GROUP_MIX_A  = 8'h00;
	localparam logic [7:0]  RST_GROUP_MIX_B  = 8'h00;
	localparam logic [7:0]  RST_POINTER      = 8'h00;
	// field positions
	localparam int          BIT_CHIP_ENABLE  = 6;
	localparam int          BIT_LOG_DIMMING  = 5;
	localparam int          BIT_POWER_SAVE   = 4;
	localparam int          BIT_AUTO_INCR    = 3;
	localparam int          BIT_PWM_DITHER   = 2;
	localparam int          BIT_MAX_CURRENT  = 1;
	localparam int          BIT_ALL_OFF      = 0;
	localparam logic [7:0]  READ_MISS_VALUE  = 8'h00;
	localparam logic [7:0]  PTR_STEP         = 8'h01;
	typedef logic [NUM_MODULES-1:0][DATA_W-1:0] ldc_bytes_t;
endpackage

// File: verif/ldc_config_bank_monitor.sv
// port assertions for the led driver configuration bank
// assumes one clock and an async active-low reset held at least one edge
module ldc_bank_monitor (
	input wire logic                i_sys_clk,          // clock
	input wire logic                i_resetn,           // reset, low
	input wire logic                i_addr_load,        // pointer load
	input wire logic [7:0]          i_addr_value,       // load value
	input wire logic                i_reg_wr,           // write
	input wire logic [7:0]          i_reg_wdata,        // write byte
	input wire logic                i_reg_rd,           // read
	input wire ldc_pkg::ldc_bytes_t i_own_intens,       // own intensity
	input wire logic [7:0]          o_reg_rdata,        // read byte
	input wire logic                o_rd_valid,         // read valid
	input wire logic                o_addr_miss,        // miss pulse
	input wire logic [7:0]          o_reg_ptr,          // pointer
	input wire logic                o_chip_enable,      // enabled
	input wire logic                o_log_dimming,      // log curve
	input wire logic                o_power_save_en,    // power save
	input wire logic                o_auto_increment,   // pointer step
	input wire logic                o_pwm_dither_en,    // dithering
	input wire logic                o_max_current_35ma, // 35 mA
	input wire logic                o_all_outputs_off,  // forced off
	input wire logic                o_outputs_active,   // sinks live
	input wire logic [7:0]          o_module_group_mode,// group select
	input wire ldc_pkg::ldc_bytes_t o_eff_intens        // eff intensity
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	logic [7:0] acc_addr;
	logic       acc;
	// a load in the same cycle overrides the held pointer
	assign acc_addr = i_addr_load ? i_addr_value : o_reg_ptr;
	assign acc = i_reg_wr | i_reg_rd;
	sequence s_wr(logic [7:0] a);
		i_reg_wr && acc_addr == a;
	endsequence
	read_answer_a: assert property (o_rd_valid == $past(i_reg_rd))
		else $error("read valid not one cycle after read");
	miss_flag_a: assert property (acc && acc_addr > 8'h05 |=> o_addr_miss)
		else $error("no miss pulse");
	miss_data_a: assert property (i_reg_rd && acc_addr > 8'h05 |=> o_reg_rdata == 8'h00)
		else $error("miss read not zero");
	ptr_step_a: assert property (acc && o_auto_increment |=> o_reg_ptr == $past(acc_addr) + 8'h01)
		else $error("pointer did not step");
	ptr_hold_a: assert property (acc && !o_auto_increment |=> o_reg_ptr == $past(acc_addr))
		else $error("pointer moved");
	chip_write_a: assert property (s_wr(8'h00) |=> o_chip_enable == $past(i_reg_wdata[6]))
		else $error("chip enable not written");
	feature_write_a: assert property (s_wr(8'h01) |=> {o_log_dimming, o_power_save_en,
		o_auto_increment, o_pwm_dither_en, o_max_current_35ma, o_all_outputs_off}
		== $past(i_reg_wdata[5:0])) else $error("feature bits not written");
	group_sel_a: assert property (s_wr(8'h02) |=> o_module_group_mode == $past(i_reg_wdata))
		else $error("group select not written");
	active_gate_a: assert property (o_outputs_active == (o_chip_enable && !o_all_outputs_off))
		else $error("outputs active wrong");
	dark_out_a: assert property (!o_outputs_active |=> o_eff_intens == '0)
		else $error("output lit while inactive");
	own_path_a: assert property (o_outputs_active && !o_module_group_mode[0]
		|=> o_eff_intens[0] == $past(i_own_intens[0])) else $error("own value not used");
endmodule
bind ldc_config_bank ldc_bank_monitor u_mon (.i_sys_clk, .i_resetn, .i_addr_load,
	.i_addr_value, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .i_own_intens, .o_reg_rdata,
	.o_rd_valid, .o_addr_miss, .o_reg_ptr, .o_chip_enable, .o_log_dimming,
	.o_power_save_en, .o_auto_increment, .o_pwm_dither_en, .o_max_current_35ma,
	.o_all_outputs_off, .o_outputs_active, .o_module_group_mode, .o_eff_intens);

// File: verif/ldc_config_bank_test.sv
// self-checking bench for the configuration bank
// assumes the host model drives the register port at falling edges
module ldc_config_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk, i_resetn, i_addr_load, i_reg_wr, i_reg_rd, o_rd_valid, o_addr_miss;
	logic o_chip_enable, o_log_dimming, o_power_save_en, o_auto_increment, o_pwm_dither_en;
	logic o_max_current_35ma, o_all_outputs_off, o_outputs_active;
	logic [7:0] i_addr_value, i_reg_wdata, o_reg_rdata, o_reg_ptr, o_module_group_mode, rq;
	logic [1:0] fq;
	ldc_pkg::ldc_bytes_t i_own_intens, i_own_mix_a, i_own_mix_b;
	ldc_pkg::ldc_bytes_t o_eff_intens, o_eff_mix_a, o_eff_mix_b;
	logic [31:0] seed = 32'h7C90;
	logic [7:0] mdl [6] = '{8'h00, 8'h3C, 8'h00, 8'hFF, 8'h00, 8'h00};
	logic [7:0] rst_tbl [6] = '{8'h00, 8'h3C, 8'h00, 8'hFF, 8'h00, 8'h00};
	logic [5:0] opts;
	int error_cnt = 0;
	int check_count = 0;
	// option bits in register order, bit 5 down to bit 0
	assign opts = {o_log_dimming, o_power_save_en, o_auto_increment, o_pwm_dither_en,
		o_max_current_35ma, o_all_outputs_off};
	ldc_config_bank u_dut (.i_sys_clk, .i_resetn, .i_addr_load, .i_addr_value, .i_reg_wr,
		.i_reg_wdata, .i_reg_rd, .i_own_intens, .i_own_mix_a, .i_own_mix_b, .o_reg_rdata,
		.o_rd_valid, .o_addr_miss, .o_reg_ptr, .o_chip_enable, .o_log_dimming,
		.o_power_save_en, .o_auto_increment, .o_pwm_dither_en, .o_max_current_35ma,
		.o_all_outputs_off, .o_outputs_active, .o_module_group_mode, .o_eff_intens,
		.o_eff_mix_a, .o_eff_mix_b);
	ldc_host_model u_host (.i_sys_clk, .i_rdata(o_reg_rdata), .i_rd_valid(o_rd_valid),
		.i_miss(o_addr_miss), .o_load(i_addr_load), .o_addr(i_addr_value),
		.o_wr(i_reg_wr), .o_wdata(i_reg_wdata), .o_rd(i_reg_rd));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected effective bytes: dark when inactive, else group or own per module
	function automatic ldc_pkg::ldc_bytes_t eff(ldc_pkg::ldc_bytes_t own, logic [7:0] g);
		ldc_pkg::ldc_bytes_t r;
		for (int m = 0; m < ldc_pkg::NUM_MODULES; m++) begin
			r[m] = !(mdl[0][6] && !mdl[1][0]) ? 8'h00 : mdl[2][m] ? g : own[m];
		end
		return r;
	endfunction
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic acc(input logic ld, input logic [7:0] a, input logic wr,
		input logic [7:0] d, input logic rd);
		u_host.xfer(ld, a, wr, d, rd, rq, fq);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// watchdog well past the few hundred cycles the run needs
	initial begin
		#200000;
		error_cnt++;
		summarize();
	end
	initial begin
		i_resetn = 1'b0;
		{i_own_intens, i_own_mix_a, i_own_mix_b} = '0;
		repeat (3) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		i_resetn = 1'b1;
		// reset table read back to back through the stepping pointer
		for (int i = 0; i < 6; i++) begin
			acc(i == 0, 8'h00, 1'b0, 8'h00, 1'b1);
			check("reset value", rq, mdl[i]);
			check("read valid", fq, 2'b10);
		end
		check("pointer", o_reg_ptr, 8'h06);
		check("options", opts, 6'b111100);
		for (int r = 0; r < 24; r++) begin
			{i_own_intens, i_own_mix_a} = {xs(), xs(), xs(), xs()};
			i_own_mix_b = {xs(), xs()};
			for (int a = 0; a < 6; a++) begin
				mdl[a] = 8'(xs());
				if (a == 0 && r[0]) mdl[a][6] = 1'b1;
				acc(1'b1, a[7:0], 1'b1, mdl[a], 1'b0);
			end
			// outside the bank: refused, read as zero, pointer steps and wraps to 00 only when stepping is on
			acc(1'b1, 8'h06, 1'b1, 8'h77, 1'b0);
			check("miss flag", fq, 2'b01);
			acc(1'b1, 8'hFF, 1'b0, 8'h00, 1'b1);
			check("miss read", {fq, rq}, 10'h300);
			check("wrap", o_reg_ptr, mdl[1][3] ? 8'h00 : 8'hFF);
			for (int a = 0; a < 6; a++) begin
				acc(1'b1, a[7:0], 1'b0, 8'h00, 1'b1);
				check("readback", rq, mdl[a]);
			end
			check("active", o_outputs_active, mdl[0][6] && !mdl[1][0]);
			check("intensity", o_eff_intens, eff(i_own_intens, mdl[3]));
			check("mix a", o_eff_mix_a, eff(i_own_mix_a, mdl[4]));
			check("mix b", o_eff_mix_b, eff(i_own_mix_b, mdl[5]));
			check("chip enable", o_chip_enable, mdl[0][6]);
			check("features", opts, mdl[1][5:0]);
			check("group select", o_module_group_mode, mdl[2]);
		end
		// reset in mid-run: strobes idle first so no access straddles the release
		acc(1'b0, 8'h00, 1'b0, 8'h00, 1'b0);
		i_resetn = 1'b0;
		repeat (2) @(negedge i_sys_clk);
		check("dark in reset", o_eff_intens, 64'h0);
		i_resetn = 1'b1;
		for (int i = 0; i < 6; i++) begin
			acc(i == 0, 8'h00, 1'b0, 8'h00, 1'b1);
			check("reset again", rq, rst_tbl[i]);
		end
		check("options again", opts, 6'b111100);
		mdl = rst_tbl;
		// stepping off: the pointer stays on the same register
		acc(1'b1, 8'h01, 1'b1, 8'h30, 1'b0);
		acc(1'b1, 8'h03, 1'b0, 8'h00, 1'b1);
		acc(1'b0, 8'h00, 1'b0, 8'h00, 1'b1);
		check("no step", {o_reg_ptr, rq}, {8'h03, mdl[3]});
		// write and read together: old value returned, new one kept
		acc(1'b1, 8'h01, 1'b1, 8'h3C, 1'b0);
		acc(1'b1, 8'h04, 1'b1, 8'h5E, 1'b1);
		check("old on collide", {o_reg_ptr, rq}, {8'h05, mdl[4]});
		acc(1'b1, 8'h04, 1'b0, 8'h00, 1'b1);
		check("new on collide", rq, 8'h5E);
		summarize();
	end
endmodule

// File: verif/ldc_host_model.sv
// host side of the byte control port, standing in for the serial front end
// assumes every task call is entered just after a falling clock edge
module ldc_host_model (
	input  wire logic       i_sys_clk,  // clock
	input  wire logic [7:0] i_rdata,    // read byte
	input  wire logic       i_rd_valid, // read valid
	input  wire logic       i_miss,     // miss pulse
	output logic            o_load,     // pointer load
	output logic      [7:0] o_addr,     // load value
	output logic            o_wr,       // write strobe
	output logic      [7:0] o_wdata,    // write byte
	output logic            o_rd        // read strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	// unused data lines toggle so a stale value can never look valid
	task automatic xfer(input logic ld, input logic [7:0] a, input logic wr,
		input logic [7:0] d, input logic rd, output logic [7:0] q, output logic [1:0] f);
		o_load = ld;
		o_addr = ld ? a : ~o_addr;
		o_wr = wr;
		o_wdata = wr ? d : ~o_wdata;
		o_rd = rd;
		@(negedge i_sys_clk);
		q = i_rdata;
		f = {i_rd_valid, i_miss};
	endtask
	initial begin
		o_addr = 8'hA5;
		o_wdata = 8'h5A;
		o_load = 1'b0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
endmodule
